// File: hw/bld_regs.svh
// register offsets, field positions and timing counts for the backlight dimming core
// assumes a 40 MHz core clock
`ifndef BLD_REGS_SVH
`define BLD_REGS_SVH

// ==========================================================
// register map
`define BLD_FAULT_ADDR     8'h02
`define BLD_CFG_ADDR       8'h10
`define BLD_DIM_ADDR       8'h11
`define BLD_BRT_ADDR       8'h12
`define BLD_BRT_HI_ADDR    8'h13
// fault_flags bit positions
`define BLD_F_OPEN         0
`define BLD_F_SHORT        1
`define BLD_F_LOWSUP       2
`define BLD_F_OVERLOAD     3
`define BLD_F_OVERHEAT     4
// cfg register fields
`define BLD_CFG_PS_LSB     0
`define BLD_CFG_SLOPE_LSB  3
`define BLD_CFG_DITH_LSB   6
// dim register fields
`define BLD_DIM_RATE_LSB   0
`define BLD_DIM_RESEN      4
`define BLD_DIM_STEADY     5
`define BLD_DIM_LSEN       6
`define BLD_DIM_LSSEL      7
// reset values
`define BLD_CFG_RST        8'h07
`define BLD_DIM_RST        8'h10
// ==========================================================
// timing
`define BLD_CLK_HZ         40000000
`define BLD_SLOPE_MAX_MS   500
// ramp step period so that a full 12-bit travel takes the slope time
`define BLD_SLOPE_UNIT_CYC ((`BLD_CLK_HZ / 1000) * `BLD_SLOPE_MAX_MS / 7 / 4096)
`define BLD_BOOST_MAX      8'hff
`endif

// File: hw/bld_pkg.sv
// types for the backlight dimming core
// assumes bld_regs.svh supplies the numeric constants
package bld_pkg;
  typedef enum logic [1:0] {BLD_SW_312 = 2'b00, BLD_SW_625 = 2'b01, BLD_SW_1250 = 2'b11} bld_sw_e;
  typedef enum logic [1:0] {BLD_OFF = 2'b00, BLD_RUN = 2'b01, BLD_HOLD = 2'b11} bld_st_e;
  typedef struct packed {
    logic [5:0] low;
    logic [5:0] mid;
    logic [5:0] high;
  } bld_cmp_s;
  typedef struct packed {
    logic low_supply;
    logic overload;
    logic hot;
    logic cool;
  } bld_prot_s;
endpackage

// File: hw/bld_core.sv
// backlight dimming core: rate select, phase shifted drivers, ramp, dither, faults
// assumes synchronous inputs, byte register port from an outside serial slave
//
// Operation
// - freq_set_pin floating or high: boost 1250 kHz, dimming 9616 Hz at 10 bits.
// - resistor bands pick boost 312/625/1250 kHz and dimming rate with resolution.
// - freq_set_pin shorted to ground: boost 1250 kHz, dimming follows the pwm input.
// - phase shifted dimming in selects 010, 011 and 100 delays each driver so they never switch together.
// - select 010: four drivers at 90 degree offsets, five and six off.
// - select 011: three drivers at 120 degree offsets, four to six off.
// - select 100: two drivers at 180 degree offsets, three to six off.
// - select 111: all six drivers in phase with zero delay.
// - 3-bit ramp field sets transition time 0 to 500 ms, both directions.
// - 2-bit dither field adds 0 to 3 extra bits of resolution.
// - steady dither bit keeps dither after a ramp or only during it.
// - with 3 dither bits one pulse in eight is one lsb longer.
// - fault causes latch in the fault register; reading clears them.
// - open flag when boost request is at maximum and a low comparator fires.
// - headroom loop raises boost request while a low comparator fires.
// - short flag: one string fully optimised and another has high comparator.
// - low supply detect off when disabled; select 0 is 2.5 V, 1 is 5.2 V.
// - low supply disables leds and boost, restarts when supply recovers.
// - low supply flag cleared by enable pin low or fault register read.
// - overload stops boost and flags; boost resumes when current drops.
// - overheat at 150 C stops leds and boost until below 130 C.
// - dimming rate from resistor band when enabled, else 4-bit rate field.
// - shutdown with outputs and boost off while enable pin is low.
`include "bld_regs.svh"

module bld_core #(
  parameter int SLOPE_UNIT = `BLD_SLOPE_UNIT_CYC
) (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  // pins
  input  wire logic                 enable_and_io_supply,
  input  wire logic [4:0]           freq_set_pin,
  input  wire logic                 pwm_in,
  // register port
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  input  wire logic [7:0]           reg_addr,
  input  wire logic [7:0]           reg_wdata,
  output logic      [7:0]           reg_rdata,
  // analog indications
  input  wire bld_pkg::bld_cmp_s    cmp,
  input  wire bld_pkg::bld_prot_s   prot,
  // power stage
  output logic      [5:0]           led_drv,
  output logic                      boost_en,
  output bld_pkg::bld_sw_e          boost_rate,
  output logic      [7:0]           boost_level,
  output logic                      low_supply_sel
);
  import bld_pkg::*;

  // ==========================================================
  // registers
  logic [7:0]  cfg, dim, fault_flags;
  logic [11:0] brt_target, brt_now;
  logic [14:0] step_cnt;
  logic [2:0]  dith_cnt;
  logic [13:0] period_cnt;
  logic        hot_lock, pwm_d;
  logic [13:0] ext_cnt, ext_period;
  bld_st_e     st;

  wire [2:0] phase_shift_select = cfg[`BLD_CFG_PS_LSB +: 3];
  wire [2:0] slope_sel          = cfg[`BLD_CFG_SLOPE_LSB +: 3];
  wire [1:0] dith_depth         = cfg[`BLD_CFG_DITH_LSB +: 2];
  wire [3:0] dimming_rate_select = dim[`BLD_DIM_RATE_LSB +: 4];
  wire       resistor_rate_enable = dim[`BLD_DIM_RESEN];
  wire       steady_dither      = dim[`BLD_DIM_STEADY];
  wire       low_supply_detect_enable = dim[`BLD_DIM_LSEN];
  assign     low_supply_sel     = dim[`BLD_DIM_LSSEL];

  // ==========================================================
  // rate decode: band 0 short to ground, 31 floating/high
  // period in 40 MHz cycles; resolution bits shown by the counter width in use
  function automatic logic [13:0] period_of(input logic [3:0] r);
    case (r)
      4'h0: period_of = 14'h2080;  // 4808 Hz
      4'h1: period_of = 14'h1a00;  // 6010 Hz
      4'h2: period_of = 14'h15aa;  // 7212 Hz
      4'h3: period_of = 14'h1292;  // 8414 Hz
      4'h4: period_of = 14'h1040;  // 9616 Hz
      4'h5: period_of = 14'h0d00;  // 12020 Hz
      4'h6: period_of = 14'h0bd2;  // 13222 Hz
      4'h7: period_of = 14'h0ad5;  // 14424 Hz
      4'h8: period_of = 14'h0a00;  // 15626 Hz
      4'h9: period_of = 14'h0949;  // 16828 Hz
      4'ha: period_of = 14'h08ac;  // 18030 Hz
      4'hb: period_of = 14'h0820;  // 19232 Hz
      4'hc: period_of = 14'h0680;  // 24040 Hz
      4'hd: period_of = 14'h056b;  // 28848 Hz
      4'he: period_of = 14'h04a5;  // 33656 Hz
      default: period_of = 14'h0410; // 38464 Hz
    endcase
  endfunction

  // band 1..8 -> 312 kHz, 9..16 -> 625 kHz, 17..24 -> 1250 kHz; within each,
  // 2402/4808/6010/9616/12020/14424/16828/19232 Hz
  wire [4:0] band       = freq_set_pin;
  wire       freq_set_pin_gnd   = (band == 5'h00);
  wire       freq_set_pin_high  = (band >= 5'h19);
  wire [2:0] band_idx   = 3'(band - 5'h01);
  wire [13:0] band_period =
      (band_idx == 3'h0) ? 14'h3fff :  // 2402 Hz, 12-bit
      (band_idx == 3'h1) ? period_of(4'h0) :
      (band_idx == 3'h2) ? period_of(4'h1) :
      (band_idx == 3'h3) ? period_of(4'h4) :
      (band_idx == 3'h4) ? period_of(4'h5) :
      (band_idx == 3'h5) ? period_of(4'h7) :
      (band_idx == 3'h6) ? period_of(4'h9) : period_of(4'hb);
  wire [13:0] res_period = freq_set_pin_high ? period_of(4'h4) : band_period;
  wire [13:0] sel_period = freq_set_pin_gnd ? ext_period :
                           resistor_rate_enable ? res_period :
                           period_of(dimming_rate_select);
  assign boost_rate = (freq_set_pin_gnd || freq_set_pin_high || band >= 5'h11) ? BLD_SW_1250 :
                      (band >= 5'h09) ? BLD_SW_625 : BLD_SW_312;

  // ==========================================================
  // input pwm period measurement for the grounded freq_set_pin case
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pwm_d      <= 1'b0;
      ext_cnt    <= 14'h0000;
      ext_period <= 14'h1040;
    end else begin
      pwm_d <= pwm_in;
      if (pwm_in && !pwm_d) begin
        ext_cnt    <= 14'h0001;
        ext_period <= (ext_cnt < 14'h0010) ? 14'h0010 : ext_cnt;
      end else if (ext_cnt != 14'h3fff) begin
        ext_cnt <= ext_cnt + 14'h0001;
      end
    end
  end

  // ==========================================================
  // protection and run state
  wire lowsup = low_supply_detect_enable && prot.low_supply;
  // hot latches at 150 C and releases only on the 130 C indication
  always_ff @(posedge clk) begin
    if (!rst_n)
      hot_lock <= 1'b0;
    else if (prot.hot)
      hot_lock <= 1'b1;
    else if (prot.cool)
      hot_lock <= 1'b0;
  end
  wire out_block = !enable_and_io_supply || lowsup || hot_lock;
  bld_st_e next_st;
  assign next_st = out_block ? BLD_OFF : prot.overload ? BLD_HOLD : BLD_RUN;
  always_ff @(posedge clk) begin
    if (!rst_n) st <= BLD_OFF;
    else        st <= next_st;
  end
  assign boost_en = (st == BLD_RUN);

  // ==========================================================
  // register port
  wire rd_fault = reg_rd && (reg_addr == `BLD_FAULT_ADDR);
  wire wr_cfg   = reg_wr && (reg_addr == `BLD_CFG_ADDR);
  wire wr_dim   = reg_wr && (reg_addr == `BLD_DIM_ADDR);
  wire wr_brt   = reg_wr && (reg_addr == `BLD_BRT_ADDR);
  wire wr_brt_h = reg_wr && (reg_addr == `BLD_BRT_HI_ADDR);
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cfg        <= `BLD_CFG_RST;
      dim        <= `BLD_DIM_RST;
      brt_target <= 12'h000;
    end else begin
      if (wr_cfg)   cfg <= reg_wdata;
      if (wr_dim)   dim <= reg_wdata;
      if (wr_brt)   brt_target[7:0]  <= reg_wdata;
      if (wr_brt_h) brt_target[11:8] <= reg_wdata[3:0];
    end
  end
  assign reg_rdata = (reg_addr == `BLD_FAULT_ADDR)  ? fault_flags :
                     (reg_addr == `BLD_CFG_ADDR)    ? cfg :
                     (reg_addr == `BLD_DIM_ADDR)    ? dim :
                     (reg_addr == `BLD_BRT_ADDR)    ? brt_now[7:0] :
                     (reg_addr == `BLD_BRT_HI_ADDR) ? {4'h0, brt_now[11:8]} : 8'h00;

  // ==========================================================
  // led fault detection and headroom loop
  wire [5:0] optimised = ~(cmp.low | cmp.mid | cmp.high);
  wire any_low   = |cmp.low;
  wire boost_max = (boost_level == `BLD_BOOST_MAX);
  wire open_ev   = boost_max && any_low;
  logic short_ev;
  always_comb begin
    short_ev = 1'b0;
    for (int i = 0; i < 6; i++)
      for (int j = 0; j < 6; j++)
        if (i != j && optimised[i] && cmp.high[j]) short_ev = 1'b1;
  end
  always_ff @(posedge clk) begin
    if (!rst_n)
      boost_level <= 8'h00;
    else if (st == BLD_OFF)
      boost_level <= 8'h00;
    else if (any_low && !boost_max)
      boost_level <= boost_level + 8'h01;
    else if ((|cmp.high) && !any_low && boost_level != 8'h00)
      boost_level <= boost_level - 8'h01;
  end

  // set beats a same-cycle read clear; enable low clears only low supply
  wire [7:0] fault_ev = {3'b000, hot_lock, prot.overload, lowsup, short_ev, open_ev};
  always_ff @(posedge clk) begin
    if (!rst_n)
      fault_flags <= 8'h00;
    else if (rd_fault)
      fault_flags <= fault_ev;
    else if (!enable_and_io_supply)
      fault_flags <= (fault_flags & ~(8'h01 << `BLD_F_LOWSUP)) | fault_ev;
    else
      fault_flags <= fault_flags | fault_ev;
  end

  // ==========================================================
  // slope ramp
  wire [14:0] step_len = 15'(SLOPE_UNIT * slope_sel);
  wire ramping = (brt_now != brt_target);
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      brt_now  <= 12'h000;
      step_cnt <= 15'h0000;
    end else if (slope_sel == 3'h0) begin
      brt_now  <= brt_target;
      step_cnt <= 15'h0000;
    end else if (ramping) begin
      if (step_cnt >= step_len) begin
        step_cnt <= 15'h0000;
        brt_now  <= (brt_now < brt_target) ? brt_now + 12'h001 : brt_now - 12'h001;
      end else begin
        step_cnt <= step_cnt + 15'h0001;
      end
    end
  end

  // ==========================================================
  // pwm period, dither and phase shifted drivers
  wire period_end = (period_cnt >= sel_period - 14'h0001);
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      period_cnt <= 14'h0000;
      dith_cnt   <= 3'h0;
    end else if (period_end) begin
      period_cnt <= 14'h0000;
      dith_cnt   <= dith_cnt + 3'h1;
    end else begin
      period_cnt <= period_cnt + 14'h0001;
    end
  end
  wire dith_on = ramping || steady_dither;
  // extra bits below the visible lsb: compare to pulse counter fraction
  wire [2:0] frac = (dith_depth == 2'h3) ? brt_now[2:0] :
                    (dith_depth == 2'h2) ? {brt_now[1:0], 1'b0} :
                    (dith_depth == 2'h1) ? {brt_now[0], 2'b00} : 3'h0;
  wire [2:0] dith_rev = {dith_cnt[0], dith_cnt[1], dith_cnt[2]};
  wire extra = dith_on && (dith_rev < frac);
  wire [11:0] coarse = brt_now >> dith_depth;
  wire [25:0] on_prod = 26'(coarse) * 26'(sel_period);
  wire [13:0] on_base = 14'(on_prod >> (12 - dith_depth));
  wire [13:0] on_time = on_base + (extra ? 14'h0001 : 14'h0000);

  function automatic logic [13:0] shifted(input logic [13:0] c, input logic [13:0] off,
                                          input logic [13:0] p);
    shifted = (c >= off) ? c - off : c + p - off;
  endfunction
  wire [13:0] q4 = sel_period >> 2;
  wire [13:0] t3 = 14'((28'(sel_period) * 28'h0000155) >> 10);
  wire [13:0] h2 = sel_period >> 1;
  logic [5:0] next_led;
  always_comb begin
    next_led = 6'h00;
    case (phase_shift_select)
      3'b010: for (int k = 0; k < 4; k++)
        next_led[k] = shifted(period_cnt, 14'(q4 * k), sel_period) < on_time;
      3'b011: for (int k = 0; k < 3; k++)
        next_led[k] = shifted(period_cnt, 14'(t3 * k), sel_period) < on_time;
      3'b100: for (int k = 0; k < 2; k++)
        next_led[k] = shifted(period_cnt, 14'(h2 * k), sel_period) < on_time;
      3'b111: next_led = {6{period_cnt < on_time}};
      default: next_led = 6'h00;
    endcase
    if (st == BLD_OFF) next_led = 6'h00;
  end
  always_ff @(posedge clk) begin
    if (!rst_n) led_drv <= 6'h00;
    else        led_drv <= next_led;
  end

  // ==========================================================
  // checks
  a_shutdown_leds_off: assert property (@(posedge clk) disable iff (!rst_n)
    !enable_and_io_supply |=> ##1 led_drv == 6'h00) else $error("leds on in shutdown");
  a_overload_boost_off: assert property (@(posedge clk) disable iff (!rst_n)
    prot.overload |=> !boost_en) else $error("boost on during overload");
  a_open_flag_set: assert property (@(posedge clk) disable iff (!rst_n)
    (boost_max && any_low) |=> fault_flags[`BLD_F_OPEN]) else $error("open flag missed");
  a_fault_sticky: assert property (@(posedge clk) disable iff (!rst_n)
    (fault_flags[`BLD_F_OVERLOAD] && !rd_fault) |=> fault_flags[`BLD_F_OVERLOAD])
    else $error("fault dropped without read");
  a_read_clears: assert property (@(posedge clk) disable iff (!rst_n)
    (rd_fault && !prot.overload) |=> !fault_flags[`BLD_F_OVERLOAD])
    else $error("read did not clear");
  a_headroom_up: assert property (@(posedge clk) disable iff (!rst_n)
    (st != BLD_OFF && any_low && !boost_max && next_st != BLD_OFF)
    |=> boost_level == $past(boost_level) + 8'h01) else $error("boost request not raised");
  a_unused_drv_off: assert property (@(posedge clk) disable iff (!rst_n)
    (phase_shift_select == 3'b011) |=> led_drv[5:3] == 3'b000)
    else $error("unused driver active");
  a_tied_same: assert property (@(posedge clk) disable iff (!rst_n)
    (phase_shift_select == 3'b111) |=> led_drv == {6{led_drv[0]}})
    else $error("tied drivers differ");
  a_hot_holds: assert property (@(posedge clk) disable iff (!rst_n)
    (hot_lock && !prot.cool) |=> ##1 led_drv == 6'h00) else $error("leds on while hot");
endmodule

// File: bench/bld_strings_model.sv
// behavioural led strings and boost stage: per-string headroom comparators
// assumes boost_level comes from the core and the knobs from the bench
module bld_strings_model #(
  parameter logic [7:0] NEED_LVL = 8'h40
) (
  // from the core
  input  wire logic [7:0]   boost_level,
  // scenario knobs
  input  wire logic [5:0]   open_mask,
  input  wire logic [5:0]   excess_mask,
  // comparators back to the core
  output bld_pkg::bld_cmp_s cmp
);
  timeunit 1ns;
  timeprecision 1ps;
  import bld_pkg::*;

  // ==========================================================
  // headroom
  // an open string never gets enough headroom, so the core keeps asking for more;
  // mid stays low so a string that is neither low nor high counts as fully optimised
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      cmp.low[i]  = open_mask[i] || (boost_level < NEED_LVL);
      cmp.mid[i]  = 1'b0;
      cmp.high[i] = !cmp.low[i] && excess_mask[i];
    end
  end
endmodule

// File: bench/bld_core_tb_top.sv
// self-checking bench for bld_core: registers, rates, phase modes, faults
// assumes bld_regs.svh on the include path and the strings model beside it
`include "bld_regs.svh"
module bld_core_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import bld_pkg::*;

  logic       clk;
  logic       rst_n;
  logic       enable_and_io_supply;
  logic [4:0] freq_set_pin;
  logic       pwm_in;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  bld_cmp_s   cmp;
  bld_prot_s  prot;
  logic [5:0] led_drv;
  logic       boost_en;
  bld_sw_e    boost_rate;
  logic [7:0] boost_level;
  logic       low_supply_sel;
  logic [5:0] open_mask;
  logic [5:0] excess_mask;
  int         error_cnt;
  int         compares;

  bld_core #(.SLOPE_UNIT(1)) bld_core_i (.clk(clk), .rst_n(rst_n),
    .enable_and_io_supply(enable_and_io_supply), .freq_set_pin(freq_set_pin),
    .pwm_in(pwm_in), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .cmp(cmp), .prot(prot),
    .led_drv(led_drv), .boost_en(boost_en), .boost_rate(boost_rate),
    .boost_level(boost_level), .low_supply_sel(low_supply_sel));
  bld_strings_model bld_strings_model_i (.boost_level(boost_level),
    .open_mask(open_mask), .excess_mask(excess_mask), .cmp(cmp));

  always #12.5 clk = ~clk;

  // ==========================================================
  // helpers; every task is entered 2 ns after a rising edge
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    cyc(1);
    reg_wr = 1'b0;
    // one idle edge so a following access never re-raises the strobe in this time step
    cyc(1);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk) d = reg_rdata;
    cyc(1);
    reg_rd = 1'b0;
    cyc(1);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk({8'h00, d}, {8'h00, e});
  endtask
  task automatic flag_chk(input int b, input logic e);
    logic [7:0] d;
    rd(`BLD_FAULT_ADDR, d);
    chk({15'h0000, d[b]}, {15'h0000, e});
  endtask
  function automatic logic cond(input int k);
    case (k)
      0: return boost_level === `BLD_BOOST_MAX;
      1: return led_drv === 6'h00 && boost_en === 1'b0;
      default: return boost_en === 1'b1;
    endcase
  endfunction
  // bounded wait; running out counts a mismatch and closes the run
  task automatic wait_for(input int k, input int bound);
    for (int i = 0; i < bound && !cond(k); i++) cyc(1);
    chk({15'h0000, cond(k)}, 16'h0001);
    if (!cond(k)) end_sim();
  endtask

  // ==========================================================
  // scenarios
  task automatic regs_reset();
    rd_chk(`BLD_CFG_ADDR, `BLD_CFG_RST);
    rd_chk(`BLD_DIM_ADDR, `BLD_DIM_RST);
    rd_chk(`BLD_FAULT_ADDR, 8'h00);
    rd_chk(8'h3f, 8'h00);
    wr(`BLD_DIM_ADDR, 8'h90);
    chk({15'h0000, low_supply_sel}, 16'h0001);
    rd_chk(`BLD_DIM_ADDR, 8'h90);
  endtask
  task automatic rate_table();
    logic [4:0] code [9] = '{5'h00, 5'h01, 5'h08, 5'h09, 5'h10, 5'h11, 5'h18, 5'h19, 5'h1f};
    bld_sw_e    exp  [9] = '{BLD_SW_1250, BLD_SW_312, BLD_SW_312, BLD_SW_625, BLD_SW_625,
                            BLD_SW_1250, BLD_SW_1250, BLD_SW_1250, BLD_SW_1250};
    for (int i = 0; i < 9; i++) begin
      freq_set_pin = code[i];
      cyc(1);
      chk({14'h0000, boost_rate}, {14'h0000, exp[i]});
    end
  endtask
  // watches led_drv for three periods: period, stagger and idle drivers
  task automatic phase_mode(input logic [2:0] ps, input int n, input logic [5:0] idle,
                            input int per);
    int         r0a;
    int         r0b;
    int         r1;
    int         same;
    int         bad;
    logic [5:0] prev;
    logic [5:0] rise;
    r0a = -1;
    r0b = -1;
    r1 = -1;
    same = 0;
    bad = 0;
    wr(`BLD_CFG_ADDR, {5'h00, ps});
    cyc(per);
    prev = led_drv;
    for (int t = 0; t < 3 * per; t++) begin
      cyc(1);
      rise = led_drv & ~prev;
      if (rise[0] && r0a >= 0 && r0b < 0) r0b = t;
      if (rise[0] && r0a < 0) r0a = t;
      if (rise[1] && r0a >= 0 && r1 < 0) r1 = t;
      if (rise[0] && rise[1]) same++;
      if ((led_drv & idle) !== 6'h00) bad++;
      if (n == 1 && led_drv !== {6{led_drv[0]}}) bad++;
      prev = led_drv;
    end
    chk(16'(bad), 16'h0000);
    chk(16'((r0b - r0a) * 25 > per * 24 && (r0b - r0a) * 25 < per * 26), 16'h0001);
    if (n > 1) begin
      chk(16'(same), 16'h0000);
      chk(16'((r1 - r0a) * n * 10 > (r0b - r0a) * 9 &&
              (r1 - r0a) * n * 10 < (r0b - r0a) * 11), 16'h0001);
    end else begin
      chk(16'(same > 0), 16'h0001);
    end
  endtask
  // 3-bit dither at 0x801: 256 of 512 steps over a 1664 cycle period is 832 on-cycles,
  // one pulse in eight is one cycle longer; eight periods are summed in any alignment
  task automatic dither_run();
    int on_a;
    int on_b;
    on_a = 0;
    on_b = 0;
    wr(`BLD_BRT_ADDR, 8'h01);
    wr(`BLD_CFG_ADDR, 8'hc7);
    wr(`BLD_DIM_ADDR, 8'h2c);
    cyc(1664);
    for (int t = 0; t < 8 * 1664; t++) begin
      cyc(1);
      on_a += led_drv[0];
    end
    wr(`BLD_DIM_ADDR, 8'h0c);
    cyc(1664);
    for (int t = 0; t < 8 * 1664; t++) begin
      cyc(1);
      on_b += led_drv[0];
    end
    chk(16'(on_a), 16'h1a01);
    chk(16'(on_b), 16'h1a00);
  endtask
  // slope code 1 with one cycle per unit: sixteen steps up, then sixteen down
  task automatic slope_run();
    logic [7:0] d;
    wr(`BLD_CFG_ADDR, 8'h0f);
    wr(`BLD_BRT_ADDR, 8'h11);
    rd(`BLD_BRT_ADDR, d);
    chk(16'(d != 8'h11), 16'h0001);
    cyc(40);
    rd_chk(`BLD_BRT_ADDR, 8'h11);
    wr(`BLD_BRT_ADDR, 8'h01);
    rd(`BLD_BRT_ADDR, d);
    chk(16'(d != 8'h01), 16'h0001);
    cyc(40);
    rd_chk(`BLD_BRT_ADDR, 8'h01);
  endtask
  // grounded rate pin: output period follows a 400 cycle input pwm
  task automatic ext_rate();
    int   r0;
    int   r1;
    logic p;
    r0 = -1;
    r1 = -1;
    wr(`BLD_CFG_ADDR, 8'h07);
    freq_set_pin = 5'h00;
    for (int t = 0; t < 3000; t++) begin
      pwm_in = (t % 400) < 200;
      p = led_drv[0];
      cyc(1);
      if (t > 1600 && led_drv[0] && !p) begin
        if (r0 < 0) r0 = t;
        else if (r1 < 0) r1 = t;
      end
    end
    chk(16'(r1 - r0), 16'h0190);
    pwm_in = 1'b0;
    freq_set_pin = 5'h18;
  endtask
  task automatic faults();
    open_mask = 6'h01;
    wait_for(0, 20000);
    // let the open condition be seen at full request before the string recovers
    cyc(2);
    open_mask = 6'h00;
    cyc(2);
    flag_chk(`BLD_F_OPEN, 1'b1);
    flag_chk(`BLD_F_OPEN, 1'b0);
    excess_mask = 6'h02;
    cyc(4);
    excess_mask = 6'h00;
    cyc(2);
    flag_chk(`BLD_F_SHORT, 1'b1);
    flag_chk(`BLD_F_SHORT, 1'b0);
    prot.low_supply = 1'b1;
    cyc(4);
    chk({15'h0000, boost_en}, 16'h0001);
    flag_chk(`BLD_F_LOWSUP, 1'b0);
    wr(`BLD_DIM_ADDR, 8'h50);
    wait_for(1, 2);
    prot.low_supply = 1'b0;
    wait_for(2, 50);
    flag_chk(`BLD_F_LOWSUP, 1'b1);
    prot.low_supply = 1'b1;
    wait_for(1, 4);
    prot.low_supply = 1'b0;
    wait_for(2, 50);
    enable_and_io_supply = 1'b0;
    wait_for(1, 2);
    enable_and_io_supply = 1'b1;
    cyc(2);
    flag_chk(`BLD_F_LOWSUP, 1'b0);
    prot.overload = 1'b1;
    cyc(2);
    chk({15'h0000, boost_en}, 16'h0000);
    prot.overload = 1'b0;
    wait_for(2, 50);
    flag_chk(`BLD_F_OVERLOAD, 1'b1);
    flag_chk(`BLD_F_OVERLOAD, 1'b0);
    prot.hot = 1'b1;
    wait_for(1, 4);
    prot.hot = 1'b0;
    cyc(10);
    chk({15'h0000, cond(1)}, 16'h0001);
    prot.cool = 1'b1;
    wait_for(2, 50);
    flag_chk(`BLD_F_OVERHEAT, 1'b1);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    enable_and_io_supply = 1'b1;
    freq_set_pin = 5'h18;
    pwm_in = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    prot = '0;
    open_mask = 6'h00;
    excess_mask = 6'h00;
    error_cnt = 0;
    compares = 0;
    cyc(16);
    rst_n = 1'b1;
    cyc(1);
    regs_reset();
    rate_table();
    freq_set_pin = 5'h18;
    wr(`BLD_DIM_ADDR, 8'h10);
    wr(`BLD_BRT_ADDR, 8'h00);
    wr(`BLD_BRT_HI_ADDR, 8'h08);
    phase_mode(3'b010, 4, 6'h30, 2080);
    phase_mode(3'b011, 3, 6'h38, 2080);
    phase_mode(3'b100, 2, 6'h3c, 2080);
    phase_mode(3'b111, 1, 6'h00, 2080);
    wr(`BLD_DIM_ADDR, 8'h0c);
    phase_mode(3'b111, 1, 6'h00, 1664);
    dither_run();
    slope_run();
    ext_rate();
    wr(`BLD_DIM_ADDR, 8'h10);
    faults();
    end_sim();
  end
endmodule
